//--- pkg/bmdu_defines.svh
// Constants shared by the BCD multiply and divide unit
`ifndef BMDU_DEFINES_SVH
`define BMDU_DEFINES_SVH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define BMDU_OP_PROD 3'h0
`define BMDU_OP_WPROD 3'h1
`define BMDU_OP_QUOT 3'h2
`define BMDU_OP_WQUOT 3'h3
`define BMDU_OP_FQUOT 3'h4

// ----------------------------------------------------------------
// Datapath sizes
// ----------------------------------------------------------------
`define BMDU_BIN_W 56
`define BMDU_DIGITS 16

// ----------------------------------------------------------------
// Area limit and float constants
// ----------------------------------------------------------------
`define BMDU_AREA_LIMIT 16'h17FF
`define BMDU_TEN6 56'h00_0000_000F_4240
`define BMDU_TEN7 56'h00_0000_0098_9680
`define BMDU_FMAX 56'h00_0000_0098_9676
`define BMDU_EXP_MAX 6'sh07
`define BMDU_EXP_MIN (-6'sh07)
`define BMDU_MASK2 4'h3
`define BMDU_MASK4 4'hF

`endif

//--- pkg/bmdu_pkg.sv
// Types of the BCD multiply and divide unit
package bmdu_pkg;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DIV = 4'h2,
        ST_CONV1 = 4'h4,
        ST_CONV2 = 4'h8
    } bmdu_state_t;

    typedef logic [2:0] bmdu_op_t;

endpackage

//--- core/bmdu_divider.sv
// Iterative restoring binary divider, one quotient bit per cycle
`timescale 1ns/1ns
`include "bmdu_defines.svh"
module bmdu_divider import bmdu_pkg::*; #(
    parameter int W = `BMDU_BIN_W
) (
    // Clock and control
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic [W-1:0] num,
    input wire logic [W-1:0] den,
    // Answer
    output logic done,
    output logic [W-1:0] quo,
    output logic [W-1:0] rem
);
    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W-1:0] r;
        logic [W-1:0] q;
    } bmdu_div_s_t;

    bmdu_div_s_t s_q, s_d;
    logic [W-1:0] t;

    // Den must stay stable while busy; the caller holds it
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        t = {s_q.r[W-2:0], s_q.q[W-1]};
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = CW'(W);
            s_d.r = '0;
            s_d.q = num;
        end else if (s_q.busy) begin
            if (t >= den) begin
                s_d.r = t - den;
                s_d.q = {s_q.q[W-2:0], 1'b1};
            end else begin
                s_d.r = t;
                s_d.q = {s_q.q[W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt == CW'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quo = s_q.q;
    assign rem = s_q.r;
endmodule // bmdu_divider

//--- core/bmdu_bin2bcd.sv
// Iterative binary to packed BCD converter (shift and add three)
`timescale 1ns/1ns
`include "bmdu_defines.svh"
module bmdu_bin2bcd import bmdu_pkg::*; #(
    parameter int W = `BMDU_BIN_W,
    parameter int D = `BMDU_DIGITS
) (
    // Clock and control
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic [W-1:0] bin,
    // Answer
    output logic done,
    output logic [4*D-1:0] bcd
);
    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W-1:0] sh;
        logic [4*D-1:0] b;
    } bmdu_cvt_s_t;

    bmdu_cvt_s_t s_q, s_d;
    logic [4*D-1:0] adj;

    // ----------------------------------------------------------------
    // Per digit correction
    // ----------------------------------------------------------------
    for (genvar i = 0; i < D; i++) begin : g_dig
        assign adj[4*i+:4] = (s_q.b[4*i+:4] > 4'h4) ?
            s_q.b[4*i+:4] + 4'h3 : s_q.b[4*i+:4];
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = CW'(W);
            s_d.sh = bin;
            s_d.b = '0;
        end else if (s_q.busy) begin
            s_d.b = {adj[4*D-2:0], s_q.sh[W-1]};
            s_d.sh = {s_q.sh[W-2:0], 1'b0};
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt == CW'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign bcd = s_q.b;
endmodule // bmdu_bin2bcd

//--- core/bmdu_top.sv
// BCD multiply, divide and float divide unit of the controller
//----------------------------------------------------------------
//----------------------------------------------------------------
`timescale 1ns/1ns
`include "bmdu_defines.svh"
module bmdu_top import bmdu_pkg::*; #(
    parameter logic [15:0] AREA_LIMIT = `BMDU_AREA_LIMIT
) (
    // Clock and control
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Instruction step
    input wire logic step,
    input wire logic exec_cond,
    input wire logic diff_mode,
    input wire bmdu_op_t op,
    // Operand words, lowest address first
    input wire logic [15:0] src_a0,
    input wire logic [15:0] src_a1,
    input wire logic [15:0] src_b0,
    input wire logic [15:0] src_b1,
    // Indirect pointers: bit 0 a, bit 1 b, bit 2 result
    input wire logic [2:0] ind_use,
    input wire logic [15:0] ptr_a,
    input wire logic [15:0] ptr_b,
    input wire logic [15:0] ptr_r,
    // Result words and flags
    output logic [15:0] res_w0,
    output logic [15:0] res_w1,
    output logic [15:0] res_w2,
    output logic [15:0] res_w3,
    output logic [3:0] res_mask,
    output logic res_wr,
    output logic fault_flag,
    output logic zero_flag,
    output logic step_done,
    output logic busy
);
    typedef struct packed {
        bmdu_state_t st;
        bmdu_op_t op;
        logic prev;
        logic [55:0] num;
        logic [55:0] den;
        logic [55:0] cval;
        logic signed [5:0] fexp;
        logic [63:0] res;
        logic [3:0] mask;
        logic fault;
        logic zero;
        logic done;
        logic wr;
        logic busy;
        logic dgo;
        logic cgo;
    } bmdu_top_s_t;

    bmdu_top_s_t s_q, s_d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic bcd_ok(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (w[4*i+:4] > 4'h9) ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic [31:0] to_bin(input logic [31:0] v);
        logic [31:0] acc;
        acc = '0;
        for (int i = 7; i >= 0; i--) begin
            acc = acc * 32'h0000_000A + {28'h000_0000, v[4*i+:4]};
        end
        return acc;
    endfunction

    function automatic logic [2:0] lead0(input logic [27:0] m);
        logic [2:0] n;
        logic hit;
        n = '0;
        hit = 1'b0;
        for (int i = 6; i > 0; i--) begin
            if (!hit && m[4*i+:4] == 4'h0) n = n + 3'h1;
            else hit = 1'b1;
        end
        return n;
    endfunction

    function automatic logic ptr_bad(input logic [15:0] p,
                                     input logic [2:0] n);
        logic [31:0] last;
        last = to_bin({16'h0000, p}) + 32'(n) - 32'h0000_0001;
        return !bcd_ok(p) || (last > {16'h0000, AREA_LIMIT});
    endfunction

    // ----------------------------------------------------------------
    // Operand decode
    // ----------------------------------------------------------------
    logic wide, flt, run, bad, acc;
    logic [31:0] a_bin, b_bin, ba, bb;
    logic [63:0] prod;
    logic [27:0] fma, fmb;
    logic [2:0] la, lb, n_src, n_res;
    logic signed [5:0] ea, eb, er;
    logic fge;
    logic [5:0] fabs;
    logic d_done, c_done;
    logic [55:0] d_quo, d_rem;
    logic [63:0] c_bcd;

    // Word groups assemble low word first
    always_comb begin
        wide = (op == `BMDU_OP_WPROD) || (op == `BMDU_OP_WQUOT);
        flt = (op == `BMDU_OP_FQUOT);
        a_bin = wide ? to_bin({src_a1, src_a0}) : to_bin({16'h0, src_a0});
        b_bin = wide ? to_bin({src_b1, src_b0}) : to_bin({16'h0, src_b0});
        prod = a_bin * b_bin;
        n_src = (wide || flt) ? 3'h2 : 3'h1;
        n_res = wide ? 3'h4 : 3'h2;
        // Float mantissa is normalised before the divide
        la = lead0({src_a1[11:0], src_a0});
        lb = lead0({src_b1[11:0], src_b0});
        fma = {src_a1[11:0], src_a0} << {la, 2'b00};
        fmb = {src_b1[11:0], src_b0} << {lb, 2'b00};
        ba = to_bin({4'h0, fma});
        bb = to_bin({4'h0, fmb});
        ea = src_a1[15] ? -$signed({3'h0, src_a1[14:12]}) :
            $signed({3'h0, src_a1[14:12]});
        eb = src_b1[15] ? -$signed({3'h0, src_b1[14:12]}) :
            $signed({3'h0, src_b1[14:12]});
        ea = ea - $signed({3'h0, la});
        eb = eb - $signed({3'h0, lb});
        fge = ba >= bb;
        er = ea - eb + (fge ? 6'sh01 : 6'sh00);
        fabs = (s_q.fexp < 6'sh00) ? 6'(-s_q.fexp) : 6'(s_q.fexp);
    end

    // Fault checks for the requested operation
    always_comb begin
        bad = 1'b0;
        case (op)
            `BMDU_OP_PROD: bad = !bcd_ok(src_a0) || !bcd_ok(src_b0);
            `BMDU_OP_WPROD: bad = !bcd_ok(src_a0) || !bcd_ok(src_a1) ||
                !bcd_ok(src_b0) || !bcd_ok(src_b1);
            `BMDU_OP_QUOT: bad = !bcd_ok(src_a0) || !bcd_ok(src_b0) ||
                (src_b0 == 16'h0000);
            `BMDU_OP_WQUOT: bad = !bcd_ok(src_a0) || !bcd_ok(src_a1) ||
                !bcd_ok(src_b0) || !bcd_ok(src_b1) ||
                ({src_b1, src_b0} == 32'h0000_0000);
            `BMDU_OP_FQUOT: bad = !bcd_ok(src_a0) ||
                !bcd_ok({4'h0, src_a1[11:0]}) || !bcd_ok(src_b0) ||
                !bcd_ok({4'h0, src_b1[11:0]}) ||
                ({src_b1[11:0], src_b0} == 28'h000_0000);
            default: bad = 1'b1;
        endcase
        // Indirect pointers must land on existing words
        if (ind_use[0] && ptr_bad(ptr_a, n_src)) bad = 1'b1;
        if (ind_use[1] && ptr_bad(ptr_b, n_src)) bad = 1'b1;
        if (ind_use[2] && ptr_bad(ptr_r, n_res)) bad = 1'b1;
    end

    // Differentiated form needs a false step before the true one
    assign run = exec_cond && !(diff_mode && s_q.prev);
    assign acc = ce && step && (s_q.st == ST_IDLE);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.wr = 1'b0;
        s_d.dgo = 1'b0;
        s_d.cgo = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                // Steps that arrive while busy are ignored
                if (step) begin
                    s_d.prev = exec_cond;
                    s_d.op = op;
                    if (!run) begin
                        s_d.done = 1'b1;
                    end else if (bad) begin
                        s_d.fault = 1'b1;
                        s_d.done = 1'b1;
                    end else if (op == `BMDU_OP_PROD ||
                                 op == `BMDU_OP_WPROD) begin
                        s_d.cval = prod[55:0];
                        s_d.cgo = 1'b1;
                        s_d.busy = 1'b1;
                        s_d.st = ST_CONV1;
                    end else if (!flt) begin
                        s_d.num = {24'h00_0000, a_bin};
                        s_d.den = {24'h00_0000, b_bin};
                        s_d.dgo = 1'b1;
                        s_d.busy = 1'b1;
                        s_d.st = ST_DIV;
                    end else if (ba == 32'h0000_0000) begin
                        // Zero numerator gives a plain zero result
                        s_d.res[31:0] = 32'h0000_0000;
                        s_d.mask = `BMDU_MASK2;
                        s_d.zero = 1'b1;
                        s_d.fault = 1'b0;
                        s_d.wr = 1'b1;
                        s_d.done = 1'b1;
                    end else begin
                        // Ratio scaled so the quotient has seven digits
                        s_d.num = fge ? {24'h00_0000, ba} * `BMDU_TEN6 :
                            {24'h00_0000, ba} * `BMDU_TEN7;
                        s_d.den = {24'h00_0000, bb};
                        s_d.fexp = er;
                        s_d.dgo = 1'b1;
                        s_d.busy = 1'b1;
                        s_d.st = ST_DIV;
                    end
                end
            end
            ST_DIV: begin
                if (d_done) begin
                    if (s_q.op == `BMDU_OP_FQUOT &&
                        (s_q.fexp > `BMDU_EXP_MAX ||
                         s_q.fexp < `BMDU_EXP_MIN ||
                         (s_q.fexp == `BMDU_EXP_MAX &&
                          d_quo > `BMDU_FMAX))) begin
                        s_d.fault = 1'b1;
                        s_d.done = 1'b1;
                        s_d.busy = 1'b0;
                        s_d.st = ST_IDLE;
                    end else begin
                        s_d.cval = d_quo;
                        s_d.num = d_rem;
                        s_d.cgo = 1'b1;
                        s_d.st = ST_CONV1;
                    end
                end
            end
            ST_CONV1: begin
                if (c_done) begin
                    case (s_q.op)
                        `BMDU_OP_WPROD: s_d.res = c_bcd;
                        `BMDU_OP_QUOT: s_d.res[15:0] = c_bcd[15:0];
                        `BMDU_OP_FQUOT: s_d.res[31:0] =
                            {s_q.fexp < 6'sh00, fabs[2:0], c_bcd[27:0]};
                        default: s_d.res[31:0] = c_bcd[31:0];
                    endcase
                    s_d.zero = (c_bcd == 64'h0);
                    if (s_q.op == `BMDU_OP_QUOT ||
                        s_q.op == `BMDU_OP_WQUOT) begin
                        s_d.cval = s_q.num;
                        s_d.cgo = 1'b1;
                        s_d.st = ST_CONV2;
                    end else begin
                        s_d.wr = 1'b1;
                        s_d.done = 1'b1;
                        s_d.fault = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_CONV2: begin
                if (c_done) begin
                    if (s_q.op == `BMDU_OP_QUOT) begin
                        s_d.res[31:16] = c_bcd[15:0];
                    end else begin
                        s_d.res[63:32] = c_bcd[31:0];
                    end
                    s_d.wr = 1'b1;
                    s_d.done = 1'b1;
                    s_d.fault = 1'b0;
                    s_d.busy = 1'b0;
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // New op, not the stored one: the zero float path writes from idle
        if (s_d.wr) begin
            s_d.mask = (s_d.op == `BMDU_OP_WPROD ||
                        s_d.op == `BMDU_OP_WQUOT) ?
                `BMDU_MASK4 : `BMDU_MASK2;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Engines
    // ----------------------------------------------------------------
    bmdu_divider #(.W(56)) u_div (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .start(s_q.dgo), .num(s_q.num), .den(s_q.den),
        .done(d_done), .quo(d_quo), .rem(d_rem)
    );

    bmdu_bin2bcd #(.W(56), .D(16)) u_cvt (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .start(s_q.cgo), .bin(s_q.cval),
        .done(c_done), .bcd(c_bcd)
    );

    assign res_w0 = s_q.res[15:0];
    assign res_w1 = s_q.res[31:16];
    assign res_w2 = s_q.res[47:32];
    assign res_w3 = s_q.res[63:48];
    assign res_mask = s_q.mask;
    assign res_wr = s_q.wr;
    assign fault_flag = s_q.fault;
    assign zero_flag = s_q.zero;
    assign step_done = s_q.done;
    assign busy = s_q.busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_no_wr_fault;
        @(posedge mclk) disable iff (sys_rst || !ce)
        res_wr |-> !fault_flag && step_done;
    endproperty
    a_no_wr_fault: assert property (p_no_wr_fault)
        else $error("result written with fault raised");

    property p_cond_off;
        @(posedge mclk) disable iff (sys_rst || !ce)
        acc && !exec_cond |=> step_done && !res_wr &&
            $stable(fault_flag) && $stable(zero_flag);
    endproperty
    a_cond_off: assert property (p_cond_off)
        else $error("false condition changed state");

    property p_diff_once;
        @(posedge mclk) disable iff (sys_rst || !ce)
        acc && diff_mode && exec_cond && s_q.prev |=>
            step_done && !busy && $stable(res_w0);
    endproperty
    a_diff_once: assert property (p_diff_once)
        else $error("differentiated step ran twice");

    property p_prod_bad;
        @(posedge mclk) disable iff (sys_rst || !ce)
        acc && exec_cond && !diff_mode && op == `BMDU_OP_PROD &&
            !bcd_ok(src_a0) |=> fault_flag && step_done;
    endproperty
    a_prod_bad: assert property (p_prod_bad)
        else $error("non-BCD factor not flagged");

    property p_quot_zero;
        @(posedge mclk) disable iff (sys_rst || !ce)
        acc && exec_cond && !diff_mode && op == `BMDU_OP_QUOT &&
            src_b0 == 16'h0000 |=> fault_flag && !res_wr;
    endproperty
    a_quot_zero: assert property (p_quot_zero)
        else $error("zero denominator not flagged");

    property p_ptr_bad;
        @(posedge mclk) disable iff (sys_rst || !ce)
        acc && run && ind_use[0] && !bcd_ok(ptr_a) |=> fault_flag;
    endproperty
    a_ptr_bad: assert property (p_ptr_bad)
        else $error("bad indirect pointer not flagged");

    property p_zero;
        @(posedge mclk) disable iff (sys_rst || !ce)
        res_wr && s_q.op == `BMDU_OP_WPROD |->
            zero_flag == ({res_w3, res_w2, res_w1, res_w0} == 64'h0);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with product");

    property p_wide_mask;
        @(posedge mclk) disable iff (sys_rst || !ce)
        res_wr && (s_q.op == `BMDU_OP_WQUOT) |-> res_mask == 4'hF;
    endproperty
    a_wide_mask: assert property (p_wide_mask)
        else $error("wide quotient not written to four words");

    property p_finish;
        @(posedge mclk) disable iff (sys_rst || !ce)
        $rose(busy) |-> ##[1:200] step_done;
    endproperty
    a_finish: assert property (p_finish)
        else $error("operation did not finish in time");
endmodule // bmdu_top

//--- test/bmdu_top_tb.sv
// Self-checking bench of the BCD multiply and divide unit
`timescale 1ns/1ns
module bmdu_top_tb;
    // ------------------------------------------------
    // Clock, reset and unit
    // ------------------------------------------------
    logic mclk = 0, sys_rst = 1, step = 0, ec = 0, dm = 0, wseen = 0, ce = 1;
    logic [2:0] op = 0, iu = 0;
    logic [15:0] a0 = 0, a1 = 0, b0 = 0, b1 = 0, pa = 0, pb = 0, pr = 0;
    logic [15:0] w0, w1, w2, w3;
    logic [3:0] msk;
    logic wr, flt, zf, done, busy;
    int errors = 0, n_checks = 0, cyc = 0;

    always #2 mclk = ~mclk;

    bmdu_top dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .step(step), .exec_cond(ec), .diff_mode(dm), .op(op),
        .src_a0(a0), .src_a1(a1), .src_b0(b0), .src_b1(b1),
        .ind_use(iu), .ptr_a(pa), .ptr_b(pb), .ptr_r(pr),
        .res_w0(w0), .res_w1(w1), .res_w2(w2), .res_w3(w3),
        .res_mask(msk), .res_wr(wr), .fault_flag(flt), .zero_flag(zf),
        .step_done(done), .busy(busy));

    // ------------------------------------------------
    // Compare and report
    // ------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Flags as {step done, write seen, fault, zero}
    task automatic cmp_flag(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One pointer value for all three keeps the driver small
    task automatic run(input logic [2:0] o, input logic c, input logic d,
            input logic [2:0] u, input logic [15:0] p, input logic [63:0] v);
        int k;
        @(posedge mclk);
        op <= o;
        ec <= c;
        dm <= d;
        iu <= u;
        {pa, pb, pr} <= {p, p, p};
        {b1, b0, a1, a0} <= v;
        step <= 1'b1;
        @(posedge mclk);
        step <= 1'b0;
        wseen = 1'b0;
        for (k = 0; k < 250 && done !== 1'b1; k++) begin
            @(negedge mclk);
            wseen = wseen | (wr === 1'b1);
        end
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_prod;
        run(3'h0, 1, 0, 3'h7, 16'h0010, 64'h0000_0034_0000_0012);
        cmp_word({28'h0, msk, w1, w0}, 64'h0000_0003_0000_0408);
        cmp_flag({done, wseen, flt, zf}, 4'hC);
        run(3'h0, 1, 0, 3'h0, 16'h0000, 64'h0000_1234_0000_0000);
        cmp_flag({done, wseen, flt, zf}, 4'hD);
    endtask

    task automatic t_wprod;
        run(3'h1, 1, 0, 3'h0, 16'h0000, 64'h0000_0002_9999_9999);
        cmp_word({w3, w2, w1, w0}, 64'h0000_0001_9999_9998);
        cmp_word({60'h0, msk}, 64'h0000_0000_0000_000F);
    endtask

    task automatic t_quot;
        run(3'h2, 1, 0, 3'h0, 16'h0000, 64'h0000_0007_0000_0100);
        cmp_word({28'h0, msk, w1, w0}, 64'h0000_0003_0002_0014);
        run(3'h2, 1, 0, 3'h0, 16'h0000, 64'h0000_0007_0000_0003);
        cmp_flag({done, wseen, flt, zf}, 4'hD);
        run(3'h3, 1, 0, 3'h0, 16'h0000, 64'h0000_1000_1234_5678);
        cmp_word({w3, w2, w1, w0}, 64'h0000_0678_0001_2345);
    endtask

    // Zero numerator right after a wide op, then 0.5e1 by 0.25e1 is 0.2e1
    task automatic t_fquot;
        run(3'h4, 1, 0, 3'h0, 16'h0000, 64'h1250_0000_1000_0000);
        cmp_word({28'h0, msk, w1, w0}, 64'h0000_0003_0000_0000);
        cmp_flag({done, wseen, flt, zf}, 4'hD);
        run(3'h4, 1, 0, 3'h0, 16'h0000, 64'h1250_0000_1500_0000);
        cmp_word({28'h0, msk, w1, w0}, 64'h0000_0003_1200_0000);
        cmp_flag({done, wseen, flt, zf}, 4'hC);
    endtask

    // Fault reads: done, no write, fault set; zero flag left out
    task automatic t_fault;
        run(3'h0, 1, 0, 3'h0, 16'h0000, 64'h0000_0002_0000_00A0);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h1, 1, 0, 3'h0, 16'h0000, 64'h00B0_0002_0000_0003);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h2, 1, 0, 3'h0, 16'h0000, 64'h0000_0000_0000_0010);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h3, 1, 0, 3'h0, 16'h0000, 64'h0000_0000_0000_0010);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h4, 1, 0, 3'h0, 16'h0000, 64'hF100_0000_7100_0000);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h0, 1, 0, 3'h1, 16'h00A0, 64'h0000_0002_0000_0003);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h0, 1, 0, 3'h4, 16'h9999, 64'h0000_0002_0000_0003);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h5, 1, 0, 3'h0, 16'h0000, 64'h0000_0002_0000_0003);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
    endtask

    // Starts with the fault flag still set from the last case
    task automatic t_skip;
        run(3'h0, 0, 0, 3'h0, 16'h0000, 64'h0000_0034_0000_0012);
        cmp_flag({done, wseen, flt, 1'b0}, 4'hA);
        run(3'h0, 1, 0, 3'h0, 16'h0000, 64'h0000_0034_0000_0012);
        cmp_flag({done, wseen, flt, zf}, 4'hC);
        run(3'h0, 1, 1, 3'h0, 16'h0000, 64'h0000_0034_0000_0012);
        cmp_flag({done, wseen, flt, zf}, 4'h8);
        run(3'h0, 0, 1, 3'h0, 16'h0000, 64'h0000_0034_0000_0012);
        run(3'h0, 1, 1, 3'h0, 16'h0000, 64'h0000_0034_0000_0012);
        cmp_flag({done, wseen, flt, zf}, 4'hC);
    endtask

    // Clock enable low must freeze a running product
    task automatic t_stall;
        int k;
        @(posedge mclk);
        op <= 3'h0;
        ec <= 1'b1;
        dm <= 1'b0;
        {b1, b0, a1, a0} <= 64'h0000_0034_0000_0012;
        step <= 1'b1;
        @(posedge mclk);
        step <= 1'b0;
        ce <= 1'b0;
        repeat (80) @(posedge mclk);
        @(negedge mclk);
        cmp_word({62'h0, done, busy}, 64'h0000_0000_0000_0001);
        @(posedge mclk);
        ce <= 1'b1;
        for (k = 0; k < 250 && done !== 1'b1; k++) @(negedge mclk);
        cmp_word({28'h0, msk, w1, w0}, 64'h0000_0003_0000_0408);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        t_prod();
        t_wprod();
        t_quot();
        t_fquot();
        t_fault();
        t_skip();
        t_stall();
        close_out();
    end
endmodule // bmdu_top_tb
